// *** hdl/etc_timer.sv ***
// Event timer with capture and single-shot modes, APB register slave.
// Assumes an APB master on MCLK_I; EVENT_I comes from another domain.
`timescale 1ns/1ps
module etc_timer
  import etc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic EVENT_I,
  input wire logic COMPANION_TICK_I,
  input wire logic PORT_OUT_I,
  output logic PIN_O,
  output logic PIN_OE_O,
  output logic IRQ_O,
  output logic EVENT_O
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_ff1_reg;
  logic rst_n;
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rst_ff1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_ff1_reg <= 1'b1;
      rst_n <= rst_ff1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  etc_cfg_s cfg_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] compare_capture_value_reg;
  logic flag_reg;
  logic run_reg;
  logic hold_reg;
  logic pw_fall_reg;
  logic wo_reg;
  logic evt_out_reg;
  logic enable_d_reg;
  logic div_reg;
  logic ev_ff1_reg;
  logic ev_ff2_reg;
  logic ev_ff3_reg;
  logic ev_lvl_reg;
  logic ack_reg;
  logic [31:0] prdata_reg;
  etc_seq_e seq_reg;
  logic tick;
  logic rise;
  logic fall;
  logic sel_edge;
  logic start_edge;
  logic stop_edge;
  logic capture_flag_set;
  logic capture_flag_mode;
  logic frozen;
  logic bus_done;
  logic wr;
  logic rd;
  logic mapped;
  logic enable_rise;
  logic at_top;

  // ----------------------------------------------------------------
  // APB slave: one wait state, effects at the pready edge
  // ----------------------------------------------------------------
  assign bus_done = PSEL_I && PENABLE_I && ack_reg;
  assign wr = bus_done && PWRITE_I;
  assign rd = bus_done && !PWRITE_I;
  assign PREADY_O = ack_reg;
  assign PRDATA_O = prdata_reg;

  always_comb
  begin
    if (PADDR_I[7:0] == ADDR_CTRL_A) mapped = 1'b1;
    else if (PADDR_I[7:0] == ADDR_CTRL_B) mapped = 1'b1;
    else if (PADDR_I[7:0] == ADDR_EVENT_CONTROL_REG) mapped = 1'b1;
    else if (PADDR_I[7:0] == ADDR_INTCTRL) mapped = 1'b1;
    else if (PADDR_I[7:0] == ADDR_INTFLAGS) mapped = 1'b1;
    else if (PADDR_I[7:0] == ADDR_STATUS) mapped = 1'b1;
    else if (PADDR_I[7:0] == ADDR_COUNT) mapped = 1'b1;
    else if (PADDR_I[7:0] == ADDR_COMPARE_CAPTURE_VALUE) mapped = 1'b1;
    else mapped = 1'b0;
  end
  assign PSLVERR_O = ack_reg && !mapped;

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= PSEL_I && PENABLE_I && !ack_reg;
      if (PSEL_I && PENABLE_I && !ack_reg && !PWRITE_I)
      begin
        prdata_reg <= 32'h0000_0000;
        if (PADDR_I[7:0] == ADDR_CTRL_A)
        begin
          prdata_reg[CONTROL_REG_FIRST_ENABLE_BIT] <= cfg_reg.enable;
          prdata_reg[CONTROL_REG_FIRST_CLOCK_SOURCE_SELECT_LSB +: 2] <= cfg_reg.clock_source_select;
        end
        else if (PADDR_I[7:0] == ADDR_CTRL_B)
        begin
          prdata_reg[CONTROL_REG_SECOND_MODE_LSB +: 3] <= cfg_reg.mode;
          prdata_reg[CONTROL_REG_SECOND_OUTEN_BIT] <= cfg_reg.out_en;
          prdata_reg[CONTROL_REG_SECOND_ASYNC_BIT] <= cfg_reg.async_en;
        end
        else if (PADDR_I[7:0] == ADDR_EVENT_CONTROL_REG)
        begin
          prdata_reg[EVENT_CONTROL_REG_CAPTEI_BIT] <= cfg_reg.capture_flag_ei;
          prdata_reg[EVENT_CONTROL_REG_EDGE_BIT] <= cfg_reg.edge_sel;
        end
        else if (PADDR_I[7:0] == ADDR_INTCTRL) prdata_reg[FLAG_BIT] <= cfg_reg.int_en;
        else if (PADDR_I[7:0] == ADDR_INTFLAGS) prdata_reg[FLAG_BIT] <= flag_reg;
        else if (PADDR_I[7:0] == ADDR_STATUS) prdata_reg[FLAG_BIT] <= run_reg;
        else if (PADDR_I[7:0] == ADDR_COUNT) prdata_reg[CNT_W-1:0] <= cnt_reg;
        else if (PADDR_I[7:0] == ADDR_COMPARE_CAPTURE_VALUE) prdata_reg[CNT_W-1:0] <= compare_capture_value_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= '0;
    end
    else if (wr)
    begin
      if (PADDR_I[7:0] == ADDR_CTRL_A)
      begin
        cfg_reg.enable <= PWDATA_I[CONTROL_REG_FIRST_ENABLE_BIT];
        cfg_reg.clock_source_select <= PWDATA_I[CONTROL_REG_FIRST_CLOCK_SOURCE_SELECT_LSB +: 2];
      end
      else if (PADDR_I[7:0] == ADDR_CTRL_B)
      begin
        cfg_reg.mode <= PWDATA_I[CONTROL_REG_SECOND_MODE_LSB +: 3];
        cfg_reg.out_en <= PWDATA_I[CONTROL_REG_SECOND_OUTEN_BIT];
        cfg_reg.async_en <= PWDATA_I[CONTROL_REG_SECOND_ASYNC_BIT];
      end
      else if (PADDR_I[7:0] == ADDR_EVENT_CONTROL_REG)
      begin
        cfg_reg.capture_flag_ei <= PWDATA_I[EVENT_CONTROL_REG_CAPTEI_BIT];
        cfg_reg.edge_sel <= PWDATA_I[EVENT_CONTROL_REG_EDGE_BIT];
      end
      else if (PADDR_I[7:0] == ADDR_INTCTRL)
      begin
        cfg_reg.int_en <= PWDATA_I[FLAG_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter tick
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n) div_reg <= 1'b0;
    else div_reg <= !div_reg;
  end

  always_comb
  begin
    if (cfg_reg.clock_source_select == CLOCK_SOURCE_SELECT_DIV1) tick = cfg_reg.enable;
    else if (cfg_reg.clock_source_select == CLOCK_SOURCE_SELECT_DIV2) tick = cfg_reg.enable && div_reg;
    else if (cfg_reg.clock_source_select == CLOCK_SOURCE_SELECT_COMPANION) tick = cfg_reg.enable && COMPANION_TICK_I;
    else tick = 1'b0;
  end

  // ----------------------------------------------------------------
  // Event input synchroniser and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_ff1_reg <= 1'b0;
      ev_ff2_reg <= 1'b0;
      ev_ff3_reg <= 1'b0;
      ev_lvl_reg <= 1'b0;
    end
    else
    begin
      ev_ff1_reg <= EVENT_I;
      ev_ff2_reg <= ev_ff1_reg;
      ev_ff3_reg <= ev_ff2_reg;
      if (ev_ff2_reg == ev_ff3_reg) ev_lvl_reg <= ev_ff3_reg;
    end
  end

  // a pulse held over a clock is seen by the agreement check
  assign rise = cfg_reg.capture_flag_ei && (ev_ff2_reg == ev_ff3_reg) && ev_ff3_reg && !ev_lvl_reg;
  assign fall = cfg_reg.capture_flag_ei && (ev_ff2_reg == ev_ff3_reg) && !ev_ff3_reg && ev_lvl_reg;
  assign sel_edge = cfg_reg.edge_sel ? fall : rise;
  assign start_edge = cfg_reg.edge_sel ? fall : rise;
  assign stop_edge = cfg_reg.edge_sel ? rise : fall;

  // ----------------------------------------------------------------
  // Mode decode helpers
  // ----------------------------------------------------------------
  // top compare; bottom and maximum are the wrap points
  assign at_top = (cnt_reg == compare_capture_value_reg);
  assign capture_flag_mode = (cfg_reg.mode == MODE_CAPTURE_FLAG_EVT) || (cfg_reg.mode == MODE_CAPTURE_FLAG_FRQ) ||
                     (cfg_reg.mode == MODE_CAPTURE_FLAG_PW) || (cfg_reg.mode == MODE_CAPTURE_FLAG_FRQPW);
  assign frozen = (cfg_reg.mode == MODE_TIMEOUT) && !run_reg;
  assign enable_rise = cfg_reg.enable && !enable_d_reg;

  always_comb
  begin
    capture_flag_set = 1'b0;
    case (cfg_reg.mode)
      MODE_PERIODIC: capture_flag_set = tick && at_top;
      MODE_TIMEOUT: capture_flag_set = tick && run_reg && at_top && !stop_edge;
      MODE_CAPTURE_FLAG_EVT: capture_flag_set = cfg_reg.enable && sel_edge;
      MODE_CAPTURE_FLAG_FRQ: capture_flag_set = cfg_reg.enable && sel_edge;
      MODE_CAPTURE_FLAG_PW: capture_flag_set = cfg_reg.enable && pw_fall_reg && fall;
      MODE_CAPTURE_FLAG_FRQPW: capture_flag_set = cfg_reg.enable && (seq_reg == SEQ_LOW) && rise;
      MODE_SINGLE: capture_flag_set = tick && run_reg && at_top;
      default: capture_flag_set = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter, compare register and run state
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= CNT_BOTTOM;
      compare_capture_value_reg <= CNT_BOTTOM;
      run_reg <= 1'b0;
      hold_reg <= 1'b0;
      pw_fall_reg <= 1'b0;
      seq_reg <= SEQ_IDLE;
      enable_d_reg <= 1'b0;
    end
    else
    begin
      enable_d_reg <= cfg_reg.enable;
      if (tick) hold_reg <= 1'b0;
      case (cfg_reg.mode)
        MODE_PERIODIC:
        begin
          // above compare the counter wraps through maximum
          if (tick) cnt_reg <= at_top ? CNT_BOTTOM : cnt_reg + CNT_ONE;
        end
        MODE_TIMEOUT:
        begin
          if (!run_reg && start_edge && cfg_reg.enable)
          begin
            run_reg <= 1'b1;
            cnt_reg <= CNT_BOTTOM;
          end
          else if (run_reg && stop_edge) run_reg <= 1'b0;
          else if (tick && run_reg) cnt_reg <= cnt_reg + CNT_ONE;
        end
        MODE_CAPTURE_FLAG_EVT:
        begin
          if (sel_edge && cfg_reg.enable) compare_capture_value_reg <= cnt_reg;
          if (tick) cnt_reg <= cnt_reg + CNT_ONE;
        end
        MODE_CAPTURE_FLAG_FRQ:
        begin
          if (sel_edge && cfg_reg.enable)
          begin
            compare_capture_value_reg <= cnt_reg;
            cnt_reg <= CNT_BOTTOM;
          end
          else if (tick) cnt_reg <= cnt_reg + CNT_ONE;
        end
        MODE_CAPTURE_FLAG_PW:
        begin
          if (rise && !pw_fall_reg && cfg_reg.enable)
          begin
            cnt_reg <= CNT_BOTTOM;
            pw_fall_reg <= 1'b1;
          end
          else if (fall && pw_fall_reg)
          begin
            compare_capture_value_reg <= cnt_reg;
            pw_fall_reg <= 1'b0;
          end
          else if (tick) cnt_reg <= cnt_reg + CNT_ONE;
        end
        MODE_CAPTURE_FLAG_FRQPW:
        begin
          case (seq_reg)
            SEQ_IDLE:
            begin
              if (rise && cfg_reg.enable)
              begin
                cnt_reg <= CNT_BOTTOM;
                seq_reg <= SEQ_HIGH;
              end
            end
            SEQ_HIGH:
            begin
              if (fall)
              begin
                compare_capture_value_reg <= cnt_reg;
                seq_reg <= SEQ_LOW;
              end
              else if (tick) cnt_reg <= cnt_reg + CNT_ONE;
            end
            SEQ_LOW:
            begin
              if (rise) seq_reg <= SEQ_DONE;
              else if (tick) cnt_reg <= cnt_reg + CNT_ONE;
            end
            SEQ_DONE:
            begin
              // count held until the compare read re-arms
              if (rd && PADDR_I[7:0] == ADDR_COMPARE_CAPTURE_VALUE) seq_reg <= SEQ_IDLE;
            end
            default: seq_reg <= SEQ_IDLE;
          endcase
          run_reg <= (seq_reg == SEQ_HIGH) || (seq_reg == SEQ_LOW);
        end
        MODE_SINGLE:
        begin
          // enable starts a shot without an event
          if (enable_rise) run_reg <= 1'b1;
          else if (!run_reg && !hold_reg && sel_edge && cfg_reg.enable)
          begin
            cnt_reg <= CNT_BOTTOM;
            run_reg <= 1'b1;
          end
          // stop at compare, ignore events until the next tick
          else if (tick && run_reg && at_top)
          begin
            run_reg <= 1'b0;
            hold_reg <= 1'b1;
          end
          else if (tick && run_reg) cnt_reg <= cnt_reg + CNT_ONE;
        end
        default: cnt_reg <= cnt_reg;
      endcase
      if (wr && PADDR_I[7:0] == ADDR_STATUS && !frozen) run_reg <= PWDATA_I[FLAG_BIT];
      if (wr && PADDR_I[7:0] == ADDR_COUNT) cnt_reg <= PWDATA_I[CNT_W-1:0];
      if (wr && PADDR_I[7:0] == ADDR_COMPARE_CAPTURE_VALUE) compare_capture_value_reg <= PWDATA_I[CNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Capture flag, event and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_reg <= 1'b0;
      evt_out_reg <= 1'b0;
    end
    else
    begin
      evt_out_reg <= capture_flag_set;
      if (capture_flag_set) flag_reg <= 1'b1;
      else if (wr && PADDR_I[7:0] == ADDR_INTFLAGS && PWDATA_I[FLAG_BIT]) flag_reg <= 1'b0;
      // compare read clears the flag in capture modes
      else if (rd && PADDR_I[7:0] == ADDR_COMPARE_CAPTURE_VALUE && capture_flag_mode && !frozen) flag_reg <= 1'b0;
    end
  end

  assign IRQ_O = flag_reg && cfg_reg.int_en;
  assign EVENT_O = evt_out_reg;

  // ----------------------------------------------------------------
  // Waveform output and pin
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n) wo_reg <= 1'b0;
    // output follows run, one clock after the edge is taken
    else wo_reg <= (cfg_reg.mode == MODE_SINGLE) && run_reg;
  end

  // asynchronous path raises the output straight from the event
  always_comb
  begin
    // Edge in flight bridges the sync delay; run covers the cycle before wo rises
    if (cfg_reg.out_en)
      PIN_O = wo_reg || ((cfg_reg.mode == MODE_SINGLE) && cfg_reg.async_en &&
              cfg_reg.enable && cfg_reg.capture_flag_ei && !hold_reg &&
              (run_reg || ((EVENT_I != cfg_reg.edge_sel) &&
              (ev_lvl_reg == cfg_reg.edge_sel))));
    else
      PIN_O = PORT_OUT_I;
  end
  assign PIN_OE_O = 1'b1;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!rst_n);

  a_irq_holds: assert property (IRQ_O && !bus_done |=> IRQ_O)
    else $error("irq dropped without a bus access");
  a_periodic_wrap: assert property ((cfg_reg.mode == MODE_PERIODIC) && tick && at_top &&
    !wr |=> cnt_reg == CNT_BOTTOM && flag_reg)
    else $error("periodic match did not restart and flag");
  a_count_advances: assert property ((cfg_reg.mode == MODE_CAPTURE_FLAG_EVT) && tick && !wr |=>
    cnt_reg == $past(cnt_reg) + CNT_ONE)
    else $error("counter did not advance on tick");
  a_capture_copy: assert property ((cfg_reg.mode == MODE_CAPTURE_FLAG_FRQ) && capture_flag_set && !wr |=>
    compare_capture_value_reg == $past(cnt_reg) && cnt_reg == CNT_BOTTOM)
    else $error("frequency capture wrong");
  a_flag_read_clear: assert property (rd && PADDR_I[7:0] == ADDR_COMPARE_CAPTURE_VALUE && capture_flag_mode &&
    !frozen && !capture_flag_set |=> !flag_reg)
    else $error("capture read did not clear flag");
  a_frozen_run: assert property (frozen && !start_edge && cfg_reg.mode == MODE_TIMEOUT |=>
    !run_reg)
    else $error("frozen run changed");
  a_shot_stops: assert property ((cfg_reg.mode == MODE_SINGLE) && tick && run_reg && at_top &&
    !enable_rise && !wr |=> !run_reg ##1 !wo_reg)
    else $error("single shot did not stop");
  a_shot_output: assert property ((cfg_reg.mode == MODE_SINGLE) && !enable_rise &&
    !run_reg && !hold_reg && sel_edge && cfg_reg.enable && !wr |=> ##1 wo_reg)
    else $error("single shot output late");
  a_pin_override: assert property (!cfg_reg.out_en |-> PIN_O == PORT_OUT_I)
    else $error("pin not from port when disabled");
  a_timeout_flag: assert property ((cfg_reg.mode == MODE_TIMEOUT) && capture_flag_set |=>
    flag_reg && evt_out_reg)
    else $error("time-out flag missing");

  c_periodic: cover property ((cfg_reg.mode == MODE_PERIODIC) && capture_flag_set);
  c_frqpw_done: cover property ((cfg_reg.mode == MODE_CAPTURE_FLAG_FRQPW) && seq_reg == SEQ_DONE);
  c_shot: cover property ((cfg_reg.mode == MODE_SINGLE) && run_reg ##1 !run_reg);

endmodule : etc_timer

// *** hdl/etc_pkg.sv ***
// Constants, register map and carrier types of the event timer.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package etc_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_EVENT_CONTROL_REG = 8'h08;
  localparam logic [7:0] ADDR_INTCTRL = 8'h0c;
  localparam logic [7:0] ADDR_INTFLAGS = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;
  localparam logic [7:0] ADDR_COMPARE_CAPTURE_VALUE = 8'h1c;
  // Field positions
  localparam int CONTROL_REG_FIRST_ENABLE_BIT = 0;
  localparam int CONTROL_REG_FIRST_CLOCK_SOURCE_SELECT_LSB = 1;
  localparam int CONTROL_REG_SECOND_MODE_LSB = 0;
  localparam int CONTROL_REG_SECOND_OUTEN_BIT = 4;
  localparam int CONTROL_REG_SECOND_ASYNC_BIT = 6;
  localparam int EVENT_CONTROL_REG_CAPTEI_BIT = 0;
  localparam int EVENT_CONTROL_REG_EDGE_BIT = 4;
  localparam int FLAG_BIT = 0;
  // Clock source selections
  localparam logic [1:0] CLOCK_SOURCE_SELECT_DIV1 = 2'h0;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_DIV2 = 2'h1;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_COMPANION = 2'h2;
  // Mode field encodings
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_CAPTURE_FLAG_EVT = 3'h2;
  localparam logic [2:0] MODE_CAPTURE_FLAG_FRQ = 3'h3;
  localparam logic [2:0] MODE_CAPTURE_FLAG_PW = 3'h4;
  localparam logic [2:0] MODE_CAPTURE_FLAG_FRQPW = 3'h5;
  localparam logic [2:0] MODE_SINGLE = 3'h6;

  typedef struct packed {
    logic enable;
    logic [1:0] clock_source_select;
    logic [2:0] mode;
    logic out_en;
    logic async_en;
    logic capture_flag_ei;
    logic edge_sel;
    logic int_en;
  } etc_cfg_s;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_HIGH = 4'b0010,
    SEQ_LOW = 4'b0100,
    SEQ_DONE = 4'b1000
  } etc_seq_e;
endpackage : etc_pkg

// *** verification/etc_event_src.sv ***
// Event channel source that feeds the event timer's capture input.
// Assumes it shares the system clock and is driven by task calls from the bench.
`timescale 1ns/1ps
module etc_event_src
(
  input wire logic clk_i,
  output logic evt_o
);
  initial evt_o = 1'b0;

  // ------------------------------------------------------------
  // Pulse generation
  // ------------------------------------------------------------
  // levels held several clocks
  task automatic pulse(input int hi, input int lo);
    @(posedge clk_i);
    evt_o <= 1'b1;
    repeat (hi) @(posedge clk_i);
    evt_o <= 1'b0;
    repeat (lo) @(posedge clk_i);
  endtask : pulse
endmodule : etc_event_src

// *** verification/etc_timer_test.sv ***
// Self-checking bench for the event timer: APB master, scoreboard, event source.
// Assumes the design package etc_pkg and the partner model etc_event_src.
`timescale 1ns/1ps
module etc_timer_test;
  import etc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, port_out, comp_tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, evt, pin, pin_oe, irq, evt_out;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int mismatches = 0;
  int total_checks = 0;
  int seed = 20;

  etc_timer dut (.MCLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EVENT_I(evt), .COMPANION_TICK_I(comp_tick),
    .PORT_OUT_I(port_out), .PIN_O(pin), .PIN_OE_O(pin_oe), .IRQ_O(irq), .EVENT_O(evt_out));
  etc_event_src ev (.clk_i(clk), .evt_o(evt));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) comp_tick <= rst_n & ~comp_tick;

  // ------------------------------------------------------------
  // Checking and APB tasks
  // ------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    total_checks++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e, input logic [32:0] m);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask : rd

  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());

  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] top;
    logic [32:0] cexp;
    logic [32:0] cmsk;
    {rst_n, psel, penable, pwrite, port_out} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_CTRL_A, 33'h0, {33{1'b1}});
    rd(8'h20, {1'b1, 32'h0}, {33{1'b1}});
    repeat (4)
    begin
      @(posedge clk);
      port_out <= 1'($random(seed));
      @(negedge clk);
      check({pin_oe, pin}, {1'b1, port_out});
    end
    top = 32'h3 + ($random(seed) & 32'h7);
    wr(ADDR_COMPARE_CAPTURE_VALUE, top);
    wr(ADDR_INTCTRL, 32'h1);
    wr(ADDR_CTRL_A, 32'h3);
    repeat (30) @(negedge clk);
    check(irq, 1'b1);
    rd(ADDR_INTFLAGS, 33'h1, {33{1'b1}});
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_INTFLAGS, 32'h1);
    rd(ADDR_INTFLAGS, 33'h0, {33{1'b1}});
    check(irq, 1'b0);
    wr(ADDR_COMPARE_CAPTURE_VALUE, 32'h10);
    wr(ADDR_COUNT, 32'hfff0);
    wr(ADDR_CTRL_A, 32'h1);
    rd(ADDR_INTFLAGS, 33'h0, {33{1'b1}});
    repeat (40) @(negedge clk);
    rd(ADDR_INTFLAGS, 33'h1, {33{1'b1}});
    for (int m = 1; m <= 5; m++)
    begin
      cmsk = (m == 2) ? 33'h0 : {33{1'b1}};
      cexp = (m == 1) ? 33'ha : (m == 2) ? 33'h0 : (m == 3) ? 33'h24 : 33'h1d;
      wr(ADDR_CTRL_A, 32'h0);
      wr(ADDR_CTRL_B, m);
      wr(ADDR_EVENT_CONTROL_REG, 32'h1);
      wr(ADDR_COMPARE_CAPTURE_VALUE, 32'ha);
      wr(ADDR_INTFLAGS, 32'h1);
      wr(ADDR_CTRL_A, 32'h1);
      ev.pulse(30, 6);
      ev.pulse(30, 6);
      rd(ADDR_INTFLAGS, 33'h1, {33{1'b1}});
      // count read before the capture register
      if (m == 5) rd(ADDR_COUNT, 33'h23, {33{1'b1}});
      rd(ADDR_COMPARE_CAPTURE_VALUE, cexp, cmsk);
      rd(ADDR_INTFLAGS, (m == 1), {33{1'b1}});
    end
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, 32'h16);
    wr(ADDR_COMPARE_CAPTURE_VALUE, 32'h14);
    wr(ADDR_COUNT, 32'h14);
    wr(ADDR_CTRL_A, 32'h5);
    repeat (5) @(negedge clk);
    check(pin, 1'b0);
    ev.pulse(4, 4);
    @(negedge clk);
    check(pin, 1'b1);
    rd(ADDR_STATUS, 33'h1, {33{1'b1}});
    repeat (60) @(negedge clk);
    check(pin, 1'b0);
    rd(ADDR_STATUS, 33'h0, {33{1'b1}});
    wr(ADDR_CTRL_B, 32'h56);
    fork
      ev.pulse(4, 4);
      begin
        @(posedge clk);
        @(negedge clk);
        check(pin, 1'b1);
      end
    join
    rd(ADDR_STATUS, 33'h1, {33{1'b1}});
    print_verdict();
  end
endmodule : etc_timer_test
